/* rtl/pbs_pkg.sv */
package pbs_pkg;
  // apb register byte offsets
  localparam logic [7:0] PBS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PBS_STAT_OFS = 8'h04;
  localparam logic [7:0] PBS_MASK_OFS = 8'h08;
  localparam logic [7:0] PBS_INFO_OFS = 8'h0c;
  // control fields
  localparam int PBS_CTRL_SERR_EN = 0;
  localparam int PBS_CTRL_PERR_EN = 1;
  localparam int PBS_CTRL_ACTIVE = 2;
  localparam logic [2:0] PBS_CTRL_RST = 3'h3;
  // status and mask fields
  localparam int PBS_ST_PERR_OWN = 0;
  localparam int PBS_ST_PERR_FAR = 1;
  localparam int PBS_ST_SERR = 2;
  localparam int PBS_ST_WAKE = 3;
  localparam int PBS_ST_HALT = 4;
  localparam logic [4:0] PBS_MASK_RST = 5'h00;
  // synchroniser lanes
  localparam int PBS_SY_CLK = 0;
  localparam int PBS_SY_RST = 1;
  localparam int PBS_SY_REQ = 2;
  localparam int PBS_SY_PERR = 3;
  localparam int PBS_SY_M66 = 4;
  localparam int PBS_SY_CRUN = 5;
  localparam int PBS_SY_MODE = 6;
  localparam logic [6:0] PBS_SY_RST_VAL = 7'h2c;
  // strap capture waits until the synchroniser holds the pin
  localparam logic [1:0] PBS_STRAP_WAIT = 2'h3;

  typedef enum logic [1:0] {PBS_ARB_IDLE, PBS_ARB_OWN, PBS_ARB_EXT} pbs_arb_t;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic clk_prev;
    logic [1:0] strap_cnt;
    logic mode_host;
    logic clk_out;
    pbs_arb_t arb;
    logic gnt3_n;
    logic own_gnt;
    logic perr_drv;
    logic [1:0] serr_pipe;
    logic serr_drv;
    logic halt_pend;
    logic halt;
    logic active_oe;
    logic [2:0] ctrl;
    logic [4:0] sts;
    logic [4:0] msk;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pbs_state_t;
endpackage

/* rtl/pbs_sideband.sv */
`timescale 1ns/10ps
// Contract
// RULE_01 - mode strap high selects host bridge with on-chip arbiter enabled
// RULE_02 - mode strap low selects guest bridge, arbiter kept disabled
// RULE_03 - host mode arbiter drives grant 3 low for requester 3
// RULE_04 - bus signals sampled only on rising edges of the bus clock; bus reset is acted on at every pclk edge instead
// RULE_05 - drive parity error low when own parity check finds an error
// RULE_06 - while generating parity, watch parity error line for receiver reports
// RULE_07 - master parity error sets status, finishes burst, halts until cleared
// RULE_08 - address parity error asserts system error two bus clocks later
// RULE_09 - environment asserts fast bus enable for a 66 MHz segment
// RULE_10 - host mode drives bus clock out 0, looped back to clock in
// RULE_11 - bus reset is always an input, driven from outside
// RULE_12 - clock run request pin is never driven
// RULE_13 - mini bus active is open drain, asserted for full performance
// RULE_14 - wake-up event pulls power management wake line low
// RULE_15 - arbiter asserts at most one grant at any time
module pbs_sideband
  import pbs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bridge_mode_select,
  input wire logic bus_clk_in,
  input wire logic bus_reset_in_n,
  input wire logic fast_bus_enable,
  output logic bus_clock_out_0,
  input wire logic arbiter_request_3_n,
  output logic arbiter_grant_3_n,
  input wire logic parity_error_n_i,
  output logic parity_error_n_o,
  output logic parity_error_n_oe,
  output logic system_error_n_o,
  output logic system_error_n_oe,
  input wire logic clock_run_request_n_i,
  output logic clock_run_request_n_o,
  output logic clock_run_request_n_oe,
  output logic mini_bus_active_n_o,
  output logic mini_bus_active_n_oe,
  output logic power_mgmt_wake_n_o,
  output logic power_mgmt_wake_n_oe,
  input wire logic own_bus_req,
  output logic own_grant,
  input wire logic par_check_err,
  input wire logic addr_par_err,
  input wire logic gen_par,
  input wire logic master_active,
  input wire logic burst_done,
  output logic master_halt,
  input wire logic wake_event,
  input wire logic full_perf_req,
  output logic irq
);

  pbs_state_t q, n;
  logic be;
  logic brst;
  logic setup;
  logic wr_acc;
  logic [4:0] w1c;
  logic [4:0] ev;

  // bus clock is sampled by pclk; edges only from the second stage
  assign be = q.s2[PBS_SY_CLK] & ~q.clk_prev;
  assign brst = ~q.s2[PBS_SY_RST];
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & q.pready & ~q.pslverr;

  always_comb begin
    n = q;
    w1c = 5'h00;
    ev = 5'h00;
    n.s1 = {bridge_mode_select, clock_run_request_n_i, fast_bus_enable,
            parity_error_n_i, arbiter_request_3_n, bus_reset_in_n,
            bus_clk_in};
    n.s2 = q.s1;
    n.clk_prev = q.s2[PBS_SY_CLK];
    // strap caught once, after release and sync fill
    if (q.strap_cnt != PBS_STRAP_WAIT) begin
      n.strap_cnt = q.strap_cnt + 2'h1;
      n.mode_host = q.s2[PBS_SY_MODE];
    end
    // RULE_10 host clock out
    n.clk_out = q.mode_host & (q.strap_cnt == PBS_STRAP_WAIT) & ~q.clk_out;
    // RULE_11 external bus reset
    if (brst) begin
      n.arb = PBS_ARB_IDLE;
      n.gnt3_n = 1'b1;
      n.own_gnt = 1'b0;
      n.perr_drv = 1'b0;
      n.serr_pipe = 2'h0;
      n.serr_drv = 1'b0;
    // RULE_04 bus edge sampling
    end else if (be) begin
      // RULE_05 own parity error
      n.perr_drv = q.ctrl[PBS_CTRL_PERR_EN] & par_check_err;
      ev[PBS_ST_PERR_OWN] = n.perr_drv;
      // RULE_06 watch receiver reports
      ev[PBS_ST_PERR_FAR] = gen_par & ~q.s2[PBS_SY_PERR];
      // RULE_08 two clock delay
      n.serr_pipe = {q.serr_pipe[0],
                     addr_par_err & q.ctrl[PBS_CTRL_SERR_EN]};
      n.serr_drv = q.serr_pipe[1];
      ev[PBS_ST_SERR] = q.serr_pipe[1];
      // RULE_01 RULE_02 arbiter only in host mode
      if (!q.mode_host) begin
        n.arb = PBS_ARB_IDLE;
        n.gnt3_n = 1'b1;
        n.own_gnt = 1'b0;
      end else begin
        // RULE_15 via idle between owners
        case (q.arb)
          PBS_ARB_IDLE: begin
            if (own_bus_req && !q.halt) begin
              n.arb = PBS_ARB_OWN;
              n.own_gnt = 1'b1;
            // RULE_03 grant to requester 3
            end else if (!q.s2[PBS_SY_REQ]) begin
              n.arb = PBS_ARB_EXT;
              n.gnt3_n = 1'b0;
            end
          end
          PBS_ARB_OWN: begin
            if (!own_bus_req || q.halt) begin
              n.arb = PBS_ARB_IDLE;
              n.own_gnt = 1'b0;
            end
          end
          PBS_ARB_EXT: begin
            if (q.s2[PBS_SY_REQ]) begin
              n.arb = PBS_ARB_IDLE;
              n.gnt3_n = 1'b1;
            end
          end
          default: begin
            n.arb = PBS_ARB_IDLE;
            n.gnt3_n = 1'b1;
            n.own_gnt = 1'b0;
          end
        endcase
      end
    end
    // RULE_07 finish burst then halt
    if ((ev[PBS_ST_PERR_OWN] || ev[PBS_ST_PERR_FAR]) && master_active) begin
      n.halt_pend = 1'b1;
    end
    if (q.halt_pend && burst_done) begin
      n.halt_pend = 1'b0;
      n.halt = 1'b1;
      ev[PBS_ST_HALT] = 1'b1;
    end
    // RULE_14 wake event
    ev[PBS_ST_WAKE] = wake_event;
    // apb: decode in setup, act at access
    n.pready = 1'b1;
    if (setup) begin
      n.pslverr = 1'b0;
      case (paddr)
        PBS_CTRL_OFS: n.prdata = {29'h0, q.ctrl};
        PBS_STAT_OFS: n.prdata = {27'h0, q.sts};
        PBS_MASK_OFS: n.prdata = {27'h0, q.msk};
        PBS_INFO_OFS: n.prdata = {24'h0, q.s2[PBS_SY_CRUN],
                                  q.s2[PBS_SY_M66], q.halt, q.halt_pend,
                                  ~q.gnt3_n, q.own_gnt, brst, q.mode_host};
        default: begin
          n.prdata = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        PBS_CTRL_OFS: n.ctrl = pwdata[2:0];
        PBS_STAT_OFS: w1c = pwdata[4:0];
        PBS_MASK_OFS: n.msk = pwdata[4:0];
        default: n.ctrl = q.ctrl;
      endcase
    end
    // set wins over a write-one clear
    n.sts = (q.sts & ~w1c) | ev;
    // RULE_07 resume once status cleared
    if (!n.sts[PBS_ST_HALT]) begin
      n.halt = 1'b0;
    end
    n.irq = |(n.sts & n.msk);
    // RULE_13 full performance request
    n.active_oe = q.ctrl[PBS_CTRL_ACTIVE] | full_perf_req;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{s1: PBS_SY_RST_VAL, s2: PBS_SY_RST_VAL, clk_prev: 1'b0,
             strap_cnt: 2'h0, mode_host: 1'b0, clk_out: 1'b0,
             arb: PBS_ARB_IDLE, gnt3_n: 1'b1, own_gnt: 1'b0,
             perr_drv: 1'b0, serr_pipe: 2'h0, serr_drv: 1'b0,
             halt_pend: 1'b0, halt: 1'b0, active_oe: 1'b0,
             ctrl: PBS_CTRL_RST, sts: 5'h00, msk: PBS_MASK_RST,
             irq: 1'b0, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign bus_clock_out_0 = q.clk_out;
  assign arbiter_grant_3_n = q.gnt3_n;
  assign own_grant = q.own_gnt;
  assign master_halt = q.halt;
  assign irq = q.irq;
  assign parity_error_n_o = 1'b0;
  assign parity_error_n_oe = q.perr_drv;
  // open drain: only ever pulls low
  assign system_error_n_o = 1'b0;
  assign system_error_n_oe = q.serr_drv;
  // RULE_12 never driven
  assign clock_run_request_n_o = 1'b1;
  assign clock_run_request_n_oe = 1'b0;
  assign mini_bus_active_n_o = 1'b0;
  assign mini_bus_active_n_oe = q.active_oe;
  assign power_mgmt_wake_n_o = 1'b0;
  assign power_mgmt_wake_n_oe = q.sts[PBS_ST_WAKE];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic strap_ok;
  assign strap_ok = (q.strap_cnt == PBS_STRAP_WAIT);

  sequence s_addr_err;
    be && !brst && addr_par_err && q.ctrl[PBS_CTRL_SERR_EN];
  endsequence
  sequence s_halt_arm;
    q.halt_pend && burst_done;
  endsequence

  property p_host_clock;
    strap_ok && q.mode_host |=> bus_clock_out_0 != $past(bus_clock_out_0);
  endproperty
  a_host_clock: assert property (p_host_clock) // RULE_10
    else $error("host mode bus clock not toggling");

  property p_guest_quiet;
    strap_ok && !q.mode_host && $past(be) && !brst
      |-> arbiter_grant_3_n && !own_grant && !bus_clock_out_0;
  endproperty
  a_guest_quiet: assert property (p_guest_quiet) // RULE_02
    else $error("guest mode drives arbiter or clock");

  property p_grant3;
    be && !brst && q.mode_host && q.arb == PBS_ARB_IDLE && !own_bus_req
      && !q.s2[PBS_SY_REQ] |=> !arbiter_grant_3_n;
  endproperty
  a_grant3: assert property (p_grant3) // RULE_03
    else $error("request 3 not granted");

  property p_one_grant;
    !(own_grant && !arbiter_grant_3_n);
  endproperty
  a_one_grant: assert property (p_one_grant) // RULE_15
    else $error("two grants at once");

  property p_perr_drive;
    be && !brst && par_check_err && q.ctrl[PBS_CTRL_PERR_EN]
      |=> parity_error_n_oe ##1 q.sts[PBS_ST_PERR_OWN];
  endproperty
  a_perr_drive: assert property (p_perr_drive) // RULE_05
    else $error("own parity error not driven");

  property p_far_perr;
    be && !brst && gen_par && !q.s2[PBS_SY_PERR] |=> q.sts[PBS_ST_PERR_FAR];
  endproperty
  a_far_perr: assert property (p_far_perr) // RULE_06
    else $error("reported parity error missed");

  property p_serr_delay;
    s_addr_err |=> q.serr_pipe[0]
      && system_error_n_oe == $past(q.serr_pipe[1]);
  endproperty
  a_serr_delay: assert property (p_serr_delay) // RULE_08
    else $error("system error stage one wrong");

  property p_serr_out;
    be && !brst && q.serr_pipe[1] |=> system_error_n_oe;
  endproperty
  a_serr_out: assert property (p_serr_out) // RULE_08
    else $error("system error not asserted");

  property p_halt;
    s_halt_arm |=> master_halt && q.sts[PBS_ST_HALT];
  endproperty
  a_halt: assert property (p_halt) // RULE_07
    else $error("master did not halt after burst");

  property p_wake;
    wake_event |=> power_mgmt_wake_n_oe;
  endproperty
  a_wake: assert property (p_wake) // RULE_14
    else $error("wake line not pulled");

  property p_active;
    full_perf_req |=> mini_bus_active_n_oe;
  endproperty
  a_active: assert property (p_active) // RULE_13
    else $error("mini active not asserted");

  // bus side state only moves at a bus edge or bus reset
  property p_bus_edge_only;
    !be && !brst |=> $stable(arbiter_grant_3_n) && $stable(own_grant)
      && $stable(parity_error_n_oe) && $stable(system_error_n_oe);
  endproperty
  a_bus_edge_only: assert property (p_bus_edge_only) // RULE_04
    else $error("bus side output moved between bus edges");

  property p_grant3_drop;
    be && !brst && q.mode_host && q.arb == PBS_ARB_EXT
      && q.s2[PBS_SY_REQ] |=> arbiter_grant_3_n;
  endproperty
  a_grant3_drop: assert property (p_grant3_drop) // RULE_03
    else $error("grant 3 held after request dropped");

  property p_perr_idle;
    be && !brst && !par_check_err |=> !parity_error_n_oe;
  endproperty
  a_perr_idle: assert property (p_perr_idle) // RULE_05
    else $error("parity error driven without an error");

  property p_bus_reset;
    brst |=> arbiter_grant_3_n && !own_grant && !parity_error_n_oe
      && !system_error_n_oe;
  endproperty
  a_bus_reset: assert property (p_bus_reset) // RULE_11
    else $error("bus reset left a grant or error driver on");

  property p_own_grant;
    be && !brst && q.mode_host && q.arb == PBS_ARB_IDLE && own_bus_req
      && !q.halt |=> own_grant;
  endproperty
  a_own_grant: assert property (p_own_grant) // RULE_01
    else $error("internal master not granted");

endmodule

/* verif/pbs_agent.sv */
`timescale 1ns/10ps
module pbs_agent (
  output logic bus_clk_in,
  input wire logic req_on,
  input wire logic perr_on,
  input wire logic rst_on,
  input wire logic fast_on,
  output logic arbiter_request_3_n,
  output logic bus_reset_in_n,
  output logic fast_bus_enable,
  input wire logic parity_error_n_o,
  input wire logic parity_error_n_oe,
  output logic parity_error_n_i
);
  // free running, every edge 12 ns after a pclk rising edge
  initial begin
    bus_clk_in = 1'b0;
    #37;
    forever #200 bus_clk_in = ~bus_clk_in;
  end
  initial begin
    {arbiter_request_3_n, bus_reset_in_n, fast_bus_enable} = 3'h6;
    forever begin
      @(negedge bus_clk_in);
      arbiter_request_3_n <= ~req_on;
      bus_reset_in_n <= ~rst_on;
      fast_bus_enable <= fast_on;
    end
  end
  // receiver reports error
  // pull-up: released line reads high
  assign parity_error_n_i =
    (perr_on || (parity_error_n_oe && !parity_error_n_o)) ? 1'b0 : 1'b1;
endmodule

/* verif/pbs_sideband_bench.sv */
`timescale 1ns/10ps
module pbs_sideband_bench
  import pbs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, bridge_mode_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, bus_clk_in, bus_reset_in_n, fast_bus_enable;
  logic bus_clock_out_0, arbiter_request_3_n, arbiter_grant_3_n;
  logic parity_error_n_i, parity_error_n_o, parity_error_n_oe;
  logic system_error_n_o, system_error_n_oe, clock_run_request_n_i;
  logic clock_run_request_n_o, clock_run_request_n_oe;
  logic mini_bus_active_n_o, mini_bus_active_n_oe;
  logic power_mgmt_wake_n_o, power_mgmt_wake_n_oe, own_bus_req;
  logic own_grant, par_check_err, addr_par_err, gen_par, master_active;
  logic burst_done, master_halt, wake_event, full_perf_req, irq;
  logic req_on, perr_on, rst_on, fast_on, e, c;
  logic serr_seen = 1'b0;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic err;
  } pbs_row_t;
  pbs_row_t rows[10] = '{
    '{1'b0, PBS_CTRL_OFS, 32'h0, 32'h3, 1'b0},
    '{1'b0, PBS_STAT_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b0, PBS_MASK_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b1, PBS_MASK_OFS, 32'hff, 32'h0, 1'b0},
    '{1'b0, PBS_MASK_OFS, 32'h0, 32'h1f, 1'b0},
    '{1'b1, PBS_CTRL_OFS, 32'h7, 32'h0, 1'b0},
    '{1'b0, PBS_CTRL_OFS, 32'h0, 32'h7, 1'b0},
    '{1'b1, PBS_INFO_OFS, 32'hff, 32'h0, 1'b0},
    '{1'b0, PBS_INFO_OFS, 32'h0, 32'h81, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}};

  // open drain: low only while driven low
  assign clock_run_request_n_i =
    (clock_run_request_n_oe && !clock_run_request_n_o) ? 1'b0 : 1'b1;

  pbs_sideband dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .bridge_mode_select, .bus_clk_in, .bus_reset_in_n,
    .fast_bus_enable, .bus_clock_out_0, .arbiter_request_3_n,
    .arbiter_grant_3_n, .parity_error_n_i, .parity_error_n_o,
    .parity_error_n_oe, .system_error_n_o, .system_error_n_oe,
    .clock_run_request_n_i, .clock_run_request_n_o,
    .clock_run_request_n_oe, .mini_bus_active_n_o, .mini_bus_active_n_oe,
    .power_mgmt_wake_n_o, .power_mgmt_wake_n_oe, .own_bus_req, .own_grant,
    .par_check_err, .addr_par_err, .gen_par, .master_active, .burst_done,
    .master_halt, .wake_event, .full_perf_req, .irq);
  pbs_agent agent (
    .bus_clk_in, .req_on, .perr_on, .rst_on, .fast_on,
    .arbiter_request_3_n, .bus_reset_in_n, .fast_bus_enable,
    .parity_error_n_o, .parity_error_n_oe, .parity_error_n_i);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // ends mid cycle so outputs are settled
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic stop_test;
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (system_error_n_oe === 1'b1)
      serr_seen <= 1'b1;
    cyc++;
    if (cyc == 4000) begin
      failures++;
      stop_test;
    end
  end

  initial begin
    {psel, penable, pwrite, own_bus_req, par_check_err} = 5'h0;
    {addr_par_err, gen_par, master_active, burst_done, wake_event} = 5'h0;
    {full_perf_req, req_on, perr_on, rst_on, fast_on} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    bridge_mode_select = 1'b1;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    chk1(arbiter_grant_3_n, 1'b1);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(r, rows[i].x);
      chk1(e, rows[i].err);
    end
    wt(2);
    chk1(mini_bus_active_n_oe, 1'b1);
    apb(1'b1, PBS_CTRL_OFS, 32'h3);
    @(posedge pclk) full_perf_req <= 1'b1;
    wt(3);
    chk1(mini_bus_active_n_oe, 1'b1);
    @(posedge pclk) full_perf_req <= 1'b0;
    wt(3);
    chk1(mini_bus_active_n_oe, 1'b0);
    chk1(clock_run_request_n_oe, 1'b0);
    chk1(mini_bus_active_n_o, 1'b0);
    chk1(system_error_n_o, 1'b0);
    chk1(power_mgmt_wake_n_o, 1'b0);
    chk1(parity_error_n_o, 1'b0);
    c = bus_clock_out_0;
    wt(0);
    chk1(bus_clock_out_0, ~c);
    req_on = 1'b1;
    wt(24);
    chk1(arbiter_grant_3_n, 1'b0);
    @(posedge pclk) own_bus_req <= 1'b1;
    wt(24);
    chk1(own_grant, 1'b0);
    req_on = 1'b0;
    wt(32);
    chk1(arbiter_grant_3_n, 1'b1);
    chk1(own_grant, 1'b1);
    @(posedge pclk) own_bus_req <= 1'b0;
    wt(24);
    @(posedge pclk) par_check_err <= 1'b1;
    wt(8);
    @(posedge pclk) par_check_err <= 1'b0;
    wt(0);
    chk1(parity_error_n_i, 1'b0);
    rd(PBS_STAT_OFS, 32'h1);
    chk1(irq, 1'b1);
    apb(1'b1, PBS_STAT_OFS, 32'h1f);
    perr_on = 1'b1;
    @(posedge pclk) gen_par <= 1'b1;
    wt(16);
    perr_on = 1'b0;
    @(posedge pclk) gen_par <= 1'b0;
    wt(2);
    rd(PBS_STAT_OFS, 32'h2);
    apb(1'b1, PBS_STAT_OFS, 32'h1f);
    @(posedge pclk) {master_active, par_check_err} <= 2'h3;
    wt(8);
    @(posedge pclk) par_check_err <= 1'b0;
    wt(2);
    chk1(master_halt, 1'b0);
    @(posedge pclk) burst_done <= 1'b1;
    @(posedge pclk) burst_done <= 1'b0;
    wt(2);
    chk1(master_halt, 1'b1);
    rd(PBS_STAT_OFS, 32'h11);
    apb(1'b1, PBS_STAT_OFS, 32'h10);
    wt(2);
    chk1(master_halt, 1'b0);
    @(posedge pclk) master_active <= 1'b0;
    apb(1'b1, PBS_STAT_OFS, 32'h1f);
    @(posedge pclk) addr_par_err <= 1'b1;
    wt(7);
    @(posedge pclk) addr_par_err <= 1'b0;
    wt(0);
    chk1(serr_seen, 1'b0);
    wt(20);
    chk1(serr_seen, 1'b1);
    rd(PBS_STAT_OFS, 32'h4);
    apb(1'b1, PBS_STAT_OFS, 32'h1f);
    apb(1'b1, PBS_MASK_OFS, 32'h0);
    @(posedge pclk) wake_event <= 1'b1;
    @(posedge pclk) wake_event <= 1'b0;
    wt(3);
    chk1(power_mgmt_wake_n_oe, 1'b1);
    chk1(irq, 1'b0);
    apb(1'b1, PBS_MASK_OFS, 32'h8);
    wt(2);
    chk1(irq, 1'b1);
    apb(1'b1, PBS_STAT_OFS, 32'h8);
    wt(2);
    chk1(irq, 1'b0);
    chk1(power_mgmt_wake_n_oe, 1'b0);
    fast_on = 1'b1;
    req_on = 1'b1;
    wt(24);
    rd(PBS_INFO_OFS, 32'hc9);
    rst_on = 1'b1;
    wt(24);
    chk1(arbiter_grant_3_n, 1'b1);
    rst_on = 1'b0;
    @(posedge pclk) {presetn, bridge_mode_select} <= 2'h0;
    wt(2);
    @(posedge pclk) presetn <= 1'b1;
    wt(32);
    chk1(arbiter_grant_3_n, 1'b1);
    chk1(bus_clock_out_0, 1'b0);
    rd(PBS_INFO_OFS, 32'hc0);
    stop_test;
  end
endmodule
